// *** verilog/split_timeout_pkg.sv ***
// Constants for split port link timeout recovery
package split_timeout_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 100;
  localparam int NS_PER_MS       = 1000000;
  localparam int CYC_PER_MS      = NS_PER_MS / CLK_PERIOD_NS;
  localparam int TO_100_MS       = 100;
  localparam int TO_250_MS       = 250;
  localparam int TO_500_MS       = 500;
  localparam int TO_750_MS       = 750;
  localparam int TO_1000_MS      = 1000;
  localparam int TO_2000_MS      = 2000;
  localparam int OFF_BASE_MS     = 350;
  localparam int OFF_STEP_MS     = 10;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] ADDR_TIMEOUT_CFG = 16'h4171;
  localparam logic [15:0] ADDR_OFF_DUR     = 16'h4176;
  localparam logic [15:0] ADDR_GLOBAL_EN   = 16'h4141;
  localparam logic [15:0] ADDR_PORT_EN     = 16'h3c48;
  localparam logic [7:0]  RST_TIMEOUT_CFG  = 8'h05;
  localparam logic [7:0]  RST_OFF_DUR      = 8'h05;
  localparam logic [7:0]  RST_GLOBAL_EN    = 8'h00;
  localparam logic [7:0]  RST_PORT_EN      = 8'h00;
  localparam logic [7:0]  MASK_TIMEOUT     = 8'h07;
  localparam logic [7:0]  MASK_GLOBAL      = 8'h01;
  localparam logic [7:0]  MASK_PORT_EN     = 8'h60;
  localparam int          PORT_EN_LSB      = 5;

  // ****************************************************************
  // Timeout select codes and link states
  // ****************************************************************
  localparam logic [2:0] SEL_OFF  = 3'h0;
  localparam logic [2:0] SEL_100  = 3'h1;
  localparam logic [2:0] SEL_250  = 3'h2;
  localparam logic [2:0] SEL_500  = 3'h3;
  localparam logic [2:0] SEL_750  = 3'h4;
  localparam logic [2:0] SEL_1000 = 3'h5;
  localparam logic [2:0] SEL_2000 = 3'h6;
  localparam logic [3:0] LS_BAD_LO = 4'h4;
  localparam logic [3:0] LS_BAD_HI = 4'h9;

endpackage : split_timeout_pkg

// *** verilog/split_port_watch.sv ***
// One port watchdog: link timeout and power-off pulse
module split_port_watch
#(
  parameter int CNT_W = 26
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // Configuration
  input  wire logic             i_enable,
  input  wire logic [CNT_W-1:0] i_limit,
  input  wire logic [CNT_W-1:0] i_off_cycles,
  // Link status, already synchronised
  input  wire logic [3:0]       i_link_state,
  // Status and pin
  output logic                  o_pwr_on,
  output logic                  o_in_reset
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [0:0] {ST_WATCH, ST_OFF} state_e;

  typedef struct packed {
    state_e           st;
    logic [CNT_W-1:0] cnt;
    logic [3:0]       last;
    logic             pwr_on;
  } state_s;

  state_s r;
  state_s next_r;
  logic   bad;

  initial
  begin
    if (CNT_W < 8 || CNT_W > 31)
      $error("CNT_W out of range");
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_r = r;
    bad = (i_link_state >= split_timeout_pkg::LS_BAD_LO) &&
          (i_link_state <= split_timeout_pkg::LS_BAD_HI); // RULE12
    next_r.last = i_link_state;
    unique case (r.st)
      ST_WATCH:
      begin
        next_r.pwr_on = 1'b1; // RULE15
        if (!i_enable || i_limit == '0) // RULE2 RULE14
          next_r.cnt = '0;
        else if (!bad || i_link_state != r.last) // RULE11 RULE16
          next_r.cnt = '0;
        else if (r.cnt >= i_limit - 1'b1)
        begin
          next_r.cnt    = '0; // RULE6
          next_r.st     = ST_OFF;
          next_r.pwr_on = 1'b0; // RULE5 RULE13
        end
        else
          next_r.cnt = r.cnt + 1'b1;
      end
      ST_OFF:
      begin
        if (r.cnt >= i_off_cycles - 1'b1) // RULE7
        begin
          next_r.cnt    = '0; // RULE9
          next_r.st     = ST_WATCH;
          next_r.pwr_on = 1'b1;
        end
        else
          next_r.cnt = r.cnt + 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      r <= '{st: ST_WATCH, cnt: '0, last: '0, pwr_on: 1'b1};
    else if (i_ce)
      r <= next_r;
  end

  assign o_pwr_on   = r.pwr_on;
  assign o_in_reset = (r.st == ST_OFF);

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_off_only_from_timeout;
    @(posedge i_clk) disable iff (i_rst)
    $fell(r.pwr_on) |-> $past(i_enable) && $past(i_limit) != '0;
  endproperty
  a_off_only_from_timeout: assert property (p_off_only_from_timeout) // RULE10
    else $error("power dropped without timeout");

  property p_on_when_disabled;
    @(posedge i_clk) disable iff (i_rst)
    (r.st == ST_WATCH) |-> r.pwr_on;
  endproperty
  a_on_when_disabled: assert property (p_on_when_disabled) // RULE15
    else $error("pin low outside pulse");

  property p_change_restarts;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && r.st == ST_WATCH && i_link_state != r.last)
      |=> r.cnt == '0 && r.pwr_on;
  endproperty
  a_change_restarts: assert property (p_change_restarts) // RULE16
    else $error("counter not restarted on state change");

  property p_good_state_clears;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && r.st == ST_WATCH && !bad) |=> r.cnt == '0;
  endproperty
  a_good_state_clears: assert property (p_good_state_clears) // RULE11
    else $error("valid link counted");

  property p_pulse_end_clears;
    @(posedge i_clk) disable iff (i_rst)
    $rose(r.pwr_on) |-> r.cnt == '0;
  endproperty
  a_pulse_end_clears: assert property (p_pulse_end_clears) // RULE9
    else $error("off timer not cleared");

  property p_fall_clears;
    @(posedge i_clk) disable iff (i_rst)
    $fell(r.pwr_on) |-> r.cnt == '0 && r.st == ST_OFF;
  endproperty
  a_fall_clears: assert property (p_fall_clears) // RULE6
    else $error("timeout counter not cleared");

endmodule : split_port_watch

// *** verilog/split_link_recovery.sv ***
// Split port link timeout recovery with register port
// Overview of operation
// RULE1 - Select codes map to 100ms through 2s
// RULE2 - Code zero never pulses the pin
// RULE3 - Code 111b reserved, treated as off
// RULE4 - One timeout shared by all ports
// RULE5 - Stuck link for full timeout pulses pin
// RULE6 - Timeout expiry clears and restarts counter
// RULE7 - Pin held off for programmed duration
// RULE8 - Duration is 350ms plus 10ms per count
// RULE9 - Off timer clears when pulse ends
// RULE10 - Duration setting alone starts no pulse
// RULE11 - Validity judged from link state status
// RULE12 - States 0x4 to 0x9 count invalid
// RULE13 - Pin driven low during reset pulse
// RULE14 - Runs only with global and port enable
// RULE15 - Pin high outside pulses and when disabled; a pulse begun before disable still holds the pin low to its end
// RULE16 - Any state change restarts the counter
module split_link_recovery
#(
  parameter int CNT_W      = 26,
  parameter int CYC_PER_MS = split_timeout_pkg::CYC_PER_MS
)
(
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Register port
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Link state per port (5 then 6)
  input  wire logic [3:0]  i_link_state_p5,
  input  wire logic [3:0]  i_link_state_p6,
  // Split power pins, high means power on
  output logic             o_split_superspeed_power_pin_p5,
  output logic             o_split_superspeed_power_pin_p6
);

  localparam int NPORT = 2;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] timeout_cfg;
    logic [7:0] off_dur;
    logic [7:0] global_en;
    logic [7:0] port_en;
    logic [7:0] rdata;
  } regs_s;

  regs_s r;
  regs_s next_r;

  logic [3:0]       ls_meta [NPORT];
  logic [3:0]       ls_sync [NPORT];
  logic [3:0]       ls_raw  [NPORT];
  logic [NPORT-1:0] pwr_on;
  logic [NPORT-1:0] in_rst;
  logic [NPORT-1:0] pin_q;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] off_cycles;
  logic [31:0]      off_ms;

  assign ls_raw[0] = i_link_state_p5;
  assign ls_raw[1] = i_link_state_p6;

  initial
  begin
    if (CNT_W < 26 || CNT_W > 31)
      $error("CNT_W too small for 2.9s at 10MHz");
    if (CYC_PER_MS < 1)
      $error("CYC_PER_MS must be positive");
  end

  // ****************************************************************
  // Timeout decode, shared by all ports
  // ****************************************************************
  always_comb
  begin
    unique case (r.timeout_cfg[2:0]) // RULE1 RULE4
      split_timeout_pkg::SEL_100:
        limit = CNT_W'(split_timeout_pkg::TO_100_MS *
                       CYC_PER_MS);
      split_timeout_pkg::SEL_250:
        limit = CNT_W'(split_timeout_pkg::TO_250_MS *
                       CYC_PER_MS);
      split_timeout_pkg::SEL_500:
        limit = CNT_W'(split_timeout_pkg::TO_500_MS *
                       CYC_PER_MS);
      split_timeout_pkg::SEL_750:
        limit = CNT_W'(split_timeout_pkg::TO_750_MS *
                       CYC_PER_MS);
      split_timeout_pkg::SEL_1000:
        limit = CNT_W'(split_timeout_pkg::TO_1000_MS *
                       CYC_PER_MS);
      split_timeout_pkg::SEL_2000:
        limit = CNT_W'(split_timeout_pkg::TO_2000_MS *
                       CYC_PER_MS);
      default:
        limit = '0; // RULE2 RULE3
    endcase
    off_ms = split_timeout_pkg::OFF_BASE_MS +
             split_timeout_pkg::OFF_STEP_MS * 32'(r.off_dur); // RULE8
    off_cycles = CNT_W'(off_ms * CYC_PER_MS);
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_comb
  begin
    next_r = r;
    if (i_wr)
    begin
      unique case (i_addr)
        split_timeout_pkg::ADDR_TIMEOUT_CFG:
          next_r.timeout_cfg = i_wdata & split_timeout_pkg::MASK_TIMEOUT;
        split_timeout_pkg::ADDR_OFF_DUR:
          next_r.off_dur = i_wdata;
        split_timeout_pkg::ADDR_GLOBAL_EN:
          next_r.global_en = i_wdata & split_timeout_pkg::MASK_GLOBAL;
        split_timeout_pkg::ADDR_PORT_EN:
          next_r.port_en = i_wdata & split_timeout_pkg::MASK_PORT_EN;
        default:
          next_r.port_en = r.port_en;
      endcase
    end
    if (i_rd)
    begin
      unique case (i_addr)
        split_timeout_pkg::ADDR_TIMEOUT_CFG:
          next_r.rdata = r.timeout_cfg;
        split_timeout_pkg::ADDR_OFF_DUR:
          next_r.rdata = r.off_dur;
        split_timeout_pkg::ADDR_GLOBAL_EN:
          next_r.rdata = r.global_en;
        split_timeout_pkg::ADDR_PORT_EN:
          next_r.rdata = r.port_en |
            8'({in_rst, {split_timeout_pkg::PORT_EN_LSB{1'b0}}} << 1);
        default:
          next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      r.timeout_cfg <= split_timeout_pkg::RST_TIMEOUT_CFG;
      r.off_dur     <= split_timeout_pkg::RST_OFF_DUR;
      r.global_en   <= split_timeout_pkg::RST_GLOBAL_EN;
      r.port_en     <= split_timeout_pkg::RST_PORT_EN;
      r.rdata       <= 8'h00;
    end
    else if (i_ce)
      r <= next_r;
  end

  assign o_rdata = r.rdata;

  // ****************************************************************
  // Per port watchdogs
  // ****************************************************************
  generate
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          ls_meta[p] <= 4'h0;
          ls_sync[p] <= 4'h0;
          pin_q[p]   <= 1'b1;
        end
        else if (i_ce)
        begin
          ls_meta[p] <= ls_raw[p];
          ls_sync[p] <= ls_meta[p];
          pin_q[p]   <= pwr_on[p]; // RULE13
        end
      end

      split_port_watch #(.CNT_W(CNT_W)) u_watch
      (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_ce         (i_ce),
        .i_enable     (r.global_en[0] &&
                       r.port_en[split_timeout_pkg::PORT_EN_LSB + p]),
        .i_limit      (limit),
        .i_off_cycles (off_cycles),
        .i_link_state (ls_sync[p]),
        .o_pwr_on     (pwr_on[p]),
        .o_in_reset   (in_rst[p])
      ); // RULE14
    end
  endgenerate

  assign o_split_superspeed_power_pin_p5 = pin_q[0];
  assign o_split_superspeed_power_pin_p6 = pin_q[1];

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_reserved_off;
    @(posedge i_clk) disable iff (i_rst)
    (r.timeout_cfg[2:0] == 3'h7 || r.timeout_cfg[2:0] == 3'h0)
      |-> limit == '0;
  endproperty
  a_reserved_off: assert property (p_reserved_off) // RULE3
    else $error("reserved or zero code gives timeout");

  property p_off_duration;
    @(posedge i_clk) disable iff (i_rst)
    r.off_dur == 8'h05 |->
      off_cycles == CNT_W'((split_timeout_pkg::OFF_BASE_MS +
                            5 * split_timeout_pkg::OFF_STEP_MS) *
                           CYC_PER_MS);
  endproperty
  a_off_duration: assert property (p_off_duration) // RULE8
    else $error("default duration not 400ms");

  property p_off_base;
    @(posedge i_clk) disable iff (i_rst)
    r.off_dur == 8'h00 |->
      off_cycles == CNT_W'(split_timeout_pkg::OFF_BASE_MS * CYC_PER_MS);
  endproperty
  a_off_base: assert property (p_off_base) // RULE8
    else $error("minimum duration wrong");

  property p_limit_100;
    @(posedge i_clk) disable iff (i_rst)
    r.timeout_cfg[2:0] == split_timeout_pkg::SEL_100 |->
      limit == CNT_W'(split_timeout_pkg::TO_100_MS * CYC_PER_MS);
  endproperty
  a_limit_100: assert property (p_limit_100) // RULE1
    else $error("code one timeout wrong");

  property p_limit_2000;
    @(posedge i_clk) disable iff (i_rst)
    r.timeout_cfg[2:0] == split_timeout_pkg::SEL_2000 |->
      limit == CNT_W'(split_timeout_pkg::TO_2000_MS * CYC_PER_MS);
  endproperty
  a_limit_2000: assert property (p_limit_2000) // RULE1
    else $error("code six timeout wrong");

  property p_pin_follows;
    @(posedge i_clk) disable iff (i_rst)
    i_ce |=> pin_q == $past(pwr_on);
  endproperty
  a_pin_follows: assert property (p_pin_follows) // RULE13
    else $error("pin does not follow pulse");

  property p_gate_global;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && !r.global_en[0] && in_rst == '0) |=> in_rst == '0;
  endproperty
  a_gate_global: assert property (p_gate_global) // RULE14
    else $error("pulse with global split off");

  property p_gate_port5;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && !r.port_en[split_timeout_pkg::PORT_EN_LSB] && !in_rst[0])
      |=> !in_rst[0];
  endproperty
  a_gate_port5: assert property (p_gate_port5) // RULE14
    else $error("pulse on disabled port 5");

  property p_gate_port6;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && !r.port_en[split_timeout_pkg::PORT_EN_LSB + 1] && !in_rst[1])
      |=> !in_rst[1];
  endproperty
  a_gate_port6: assert property (p_gate_port6) // RULE14
    else $error("pulse on disabled port 6");

  // ****************************************************************
  // Register checks
  // ****************************************************************
  property p_cfg_masked;
    @(posedge i_clk) disable iff (i_rst)
    r.timeout_cfg[7:3] == '0;
  endproperty
  a_cfg_masked: assert property (p_cfg_masked) // RULE1
    else $error("timeout reserved bits set");

  property p_dur_write;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && i_wr && i_addr == split_timeout_pkg::ADDR_OFF_DUR)
      |=> r.off_dur == $past(i_wdata);
  endproperty
  a_dur_write: assert property (p_dur_write) // RULE7
    else $error("duration write lost");

  property p_cfg_read;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && i_rd && i_addr == split_timeout_pkg::ADDR_TIMEOUT_CFG)
      |=> o_rdata == $past(r.timeout_cfg);
  endproperty
  a_cfg_read: assert property (p_cfg_read) // RULE1
    else $error("timeout read data wrong");

endmodule : split_link_recovery

// *** dv/split_dev_model.sv ***
// Embedded superspeed device model driving link state
module split_dev_model
(
  // Clock
  input  wire logic       i_clk,
  // Power pin and behaviour: 0 trains, 1 sticks, 2 hops
  input  wire logic       i_pwr,
  input  wire logic [1:0] i_mode,
  // Link state seen by the hub
  output logic      [3:0] o_link_state
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] step;
  initial step = 4'h0;
  initial o_link_state = 4'h5;
  always @(posedge i_clk)
  begin
    step <= step + 4'h1;
    if (!i_pwr)
      o_link_state <= 4'h5;
    else if (i_mode == 2'h1)
      o_link_state <= 4'h7;
    else if (i_mode == 2'h2)
      o_link_state <= step[3] ? 4'h8 : 4'h7;
    else
      o_link_state <= 4'h0;
  end
endmodule : split_dev_model

// *** dv/tb_split_link_recovery.sv ***
// Testbench for split port link timeout recovery
module tb_split_link_recovery;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Signals
  // ********
  localparam int CYC = 1;
  localparam int LIM = split_timeout_pkg::TO_100_MS * CYC;
  localparam int OFF = split_timeout_pkg::OFF_BASE_MS * CYC;
  typedef struct packed
  {
    logic [15:0] addr;
    logic [7:0]  rst;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
  } row_s;
  logic        i_clk;
  logic        i_rst;
  logic        ce;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [7:0]  d;
  logic [3:0]  ls5;
  logic [3:0]  ls6;
  logic        pin5;
  logic        pin6;
  logic [1:0]  m5;
  int          num_errors;
  int          compares;
  int          top_lows;
  int          n;
  row_s        rows [6];
  // ********
  // Design, partner model and clock
  // ********
  split_link_recovery #(.CNT_W(26), .CYC_PER_MS(CYC)) u_split_link_recovery
  (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_link_state_p5(ls5), .i_link_state_p6(ls6),
    .o_split_superspeed_power_pin_p5(pin5),
    .o_split_superspeed_power_pin_p6(pin6)
  );
  split_dev_model u_split_dev_model
  (
    .i_clk(i_clk), .i_pwr(pin5), .i_mode(m5), .o_link_state(ls5)
  );
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    if (pin6 !== 1'b1)
      top_lows <= top_lows + 1;
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic wait_pin(input logic v);
    n = 0;
    while (pin5 !== v && n < 500)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    if (pin5 !== v)
    begin
      num_errors++;
      $display("Error wait for pin expected %0h seen %0h", v, pin5);
      summarize();
    end
  endtask : wait_pin
  task automatic count_low(input int cyc);
    n = 0;
    repeat (cyc)
    begin
      @(posedge i_clk);
      #1 n += (pin5 !== 1'b1);
    end
  endtask : count_low
  // ********
  // Sequence
  // ********
  initial
  begin
    rows[0] = '{16'h4171, 8'h05, 8'hff, 8'h07};
    rows[1] = '{16'h4176, 8'h05, 8'ha5, 8'ha5};
    rows[2] = '{16'h4141, 8'h00, 8'hff, 8'h01};
    rows[3] = '{16'h3c48, 8'h00, 8'hff, 8'h60};
    rows[4] = '{16'h1234, 8'h00, 8'hff, 8'h00};
    rows[5] = '{16'h4172, 8'h00, 8'hff, 8'h00};
    i_rst = 1'b1;
    ce = 1'b1;
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ls6 = 4'h5;
    m5 = 2'h1;
    num_errors = 0;
    compares = 0;
    top_lows = 0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (rows[i])
    begin
      rd_reg(rows[i].addr);
      chk("reset value", d, rows[i].rst);
      wr_reg(rows[i].addr, rows[i].wdata);
      rd_reg(rows[i].addr);
      chk("read back", d, rows[i].rdata);
    end
    wr_reg(split_timeout_pkg::ADDR_TIMEOUT_CFG, 8'h00);
    wr_reg(split_timeout_pkg::ADDR_OFF_DUR, 8'h00);
    $display("test registers done");
    count_low(150);
    chk("code zero lows", n, 0);
    wr_reg(split_timeout_pkg::ADDR_PORT_EN, 8'h00);
    wr_reg(split_timeout_pkg::ADDR_TIMEOUT_CFG, 8'h01);
    count_low(150);
    chk("disabled lows", n, 0);
    wr_reg(split_timeout_pkg::ADDR_PORT_EN, 8'h20);
    @(posedge i_clk);
    m5 <= 2'h2;
    count_low(200);
    chk("hopping lows", n, 0);
    @(posedge i_clk);
    m5 <= 2'h0;
    count_low(150);
    chk("trained lows", n, 0);
    $display("test no pulse done");
    @(posedge i_clk);
    m5 <= 2'h1;
    wait_pin(1'b0);
    chk("first timeout", n >= LIM && n <= LIM + 8, 1);
    chk("pin low in pulse", pin5, 0);
    wait_pin(1'b1);
    chk("first pulse", n >= OFF - 1 && n <= OFF + 1, 1);
    wait_pin(1'b0);
    chk("second timeout", n >= LIM && n <= LIM + 8, 1);
    wait_pin(1'b1);
    chk("second pulse", n >= OFF - 1 && n <= OFF + 1, 1);
    $display("test pulse done");
    wait_pin(1'b0);
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    #1 chk("pin in reset", pin5, 1);
    @(posedge i_clk);
    i_rst <= 1'b0;
    rd_reg(split_timeout_pkg::ADDR_TIMEOUT_CFG);
    chk("reset again", d, split_timeout_pkg::RST_TIMEOUT_CFG);
    chk("top pin lows", top_lows, 0);
    $display("test reset mid pulse done");
    summarize();
  end
endmodule : tb_split_link_recovery
